/* i2c_mgmt_pkg.sv */
// Constants and types shared by the serial management slave port
package i2c_mgmt_pkg;
  // System clock period
  localparam int CLK_PERIOD_NS = 25;
  // Shortest pulse the line filters pass
  localparam int SPIKE_NS = 100;
  // Least time, rounded up to whole cycles
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Default seven-bit slave identity
  localparam logic [6:0] DEFAULT_SLAVE_ID = 7'h0A;
  // Register word address (byte address with two zero bits appended)
  localparam int REG_ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int WR_W = REG_ADDR_W + DATA_W;
  // Write buffer depth
  localparam int WR_FIFO_DEPTH = 4;
  // Bit and byte counts
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [1:0] COMMIT_BYTE = 2'h2;
  // Address step per register word
  localparam logic [REG_ADDR_W-1:0] ADDR_STEP = 10'h004;
  localparam logic [REG_ADDR_W-1:0] ADDR_RESET = 10'h000;
  // Idle level of both lines
  localparam logic LINE_IDLE = 1'b1;
  // Protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CTRL,
    ST_REGADR,
    ST_WRDATA,
    ST_SLVACK,
    ST_RDLOAD,
    ST_RDDATA,
    ST_MSTACK,
    ST_IGNORE
  } slave_state_t;
endpackage : i2c_mgmt_pkg

/* mgmt_line_filter.sv */
// Two-stage synchroniser and spike filter for one bus line
`timescale 1ns/1ps
module mgmt_line_filter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Line
  input wire logic lineIn,
  output logic lineOut
);
  import i2c_mgmt_pkg::*;

  logic sync1_reg;
  logic sync2_reg;
  logic [3:0] stableCnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // Two flops; the first is read only by the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= LINE_IDLE;
      sync2_reg <= LINE_IDLE;
    end else begin
      sync1_reg <= lineIn;
      sync2_reg <= sync1_reg;
    end
  end

  // A new level must persist for the full spike time before it is passed
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stableCnt_reg <= 4'h0;
      lineOut <= LINE_IDLE;
    end else if (sync2_reg == lineOut) begin
      stableCnt_reg <= 4'h0;
    end else if (stableCnt_reg == 4'(SPIKE_CYC - 1)) begin
      lineOut <= sync2_reg; // [RULE1]
      stableCnt_reg <= 4'h0;
    end else begin
      stableCnt_reg <= stableCnt_reg + 4'h1;
    end
  end
endmodule : mgmt_line_filter

/* mgmt_wr_fifo.sv */
// Small FIFO for completed register writes
`timescale 1ns/1ps
module mgmt_wr_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Honest flags from the occupancy count
  assign inReady = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Storage; no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap at the power-of-two depth
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : mgmt_wr_fifo

/* i2c_slave_mgmt_port.sv */
// Two-wire management slave giving a host access to system registers
`timescale 1ns/1ps

// Operation
// RULE1: Filter out clock and data spikes below 100ns
// RULE2: Never drive clock; data only low or released
// RULE3: Data edge while clock high: start/stop
// RULE4: Repeated start keeps busy, acts as start
// RULE5: Sample on clock high, eight bits, MSB first
// RULE6: Ninth pulse acknowledges; receiver pulls data low
// RULE7: Master nack ends slave data output
// RULE8: Active only with management mode strap set
// RULE9: Works at 100kHz and 400kHz clock rates
// RULE10: Control byte: seven-bit identity plus direction
// RULE11: Override strap selects strapped identity
// RULE12: Ack match; mismatch ignored until start
// RULE13: Write direction: register address byte follows
// RULE14: Start/stop after address keeps new address
// RULE15: Read direction: data follows control ack
// RULE16: Word access; address byte plus two zeros
// RULE17: Inert until configuration inputs are valid
// RULE18: Inert outside full power state
// RULE19: Host polls test pattern then ready bit
// RULE20: Host uses single reads while polling
// RULE21: Four bytes per read; ack continues, wraps
// RULE22: Write committed only after full 32 bits
// RULE23: Capture whole word before shifting out
// RULE24: Read side effects after third byte ack
// RULE25: Synchronise lines, detect in system clock
// RULE26: Reset to idle with address zero
module i2c_slave_mgmt_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Serial bus pins
  input wire logic mgmtSerialClockPin,
  input wire logic mgmtSerialDataIn,
  output logic mgmtSerialDataOut,
  output logic mgmtSerialDataOeN,
  // Configuration and power
  input wire logic configValid,
  input wire logic serialMgmtModeStrap,
  input wire logic addrOverrideStrap,
  input wire logic [6:0] addrStrap,
  input wire logic fullPowerState,
  // Register read port
  output logic [i2c_mgmt_pkg::REG_ADDR_W-1:0] regAddr,
  output logic regRdStrobe,
  input wire logic [i2c_mgmt_pkg::DATA_W-1:0] regRdData,
  output logic regRdCommit,
  // Register write port
  output logic regWrValid,
  input wire logic regWrReady,
  output logic [i2c_mgmt_pkg::REG_ADDR_W-1:0] regWrAddr,
  output logic [i2c_mgmt_pkg::DATA_W-1:0] regWrData,
  // Status
  output logic busBusy
);
  import i2c_mgmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic sclF;
  logic sdaF;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic strapsTaken_reg;
  logic modeOn_reg;
  logic [6:0] slaveId_reg;
  logic active;
  slave_state_t state_reg;
  slave_state_t afterAck_reg;
  logic [3:0] bitCnt_reg;
  logic [1:0] byteIdx_reg;
  logic [7:0] rxByte_reg;
  logic [7:0] rxNow;
  logic [DATA_W-1:0] txWord_reg;
  logic [DATA_W-1:0] wrWord_reg;
  logic mstAck_reg;
  logic fifoInValid;
  logic fifoInReady;
  logic [WR_W-1:0] fifoInData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [WR_W-1:0] fifoOutData;

  ////////////////////////////////////////////////////////////////////////
  // Line conditioning: each line is synchronised and filtered before
  // any edge logic sees it, so the system clock must run well above
  // the bus rate; 40 MHz leaves ample margin at 400 kHz.
  mgmt_line_filter u_scl_filter (
    .mclk(mclk),
    .rstn(rstn),
    .lineIn(mgmtSerialClockPin),
    .lineOut(sclF)
  ); // [RULE25] [RULE9]

  mgmt_line_filter u_sda_filter (
    .mclk(mclk),
    .rstn(rstn),
    .lineIn(mgmtSerialDataIn),
    .lineOut(sdaF)
  ); // [RULE25]

  // Previous filtered levels for edge detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclPrev_reg <= LINE_IDLE;
      sdaPrev_reg <= LINE_IDLE;
    end else begin
      sclPrev_reg <= sclF;
      sdaPrev_reg <= sdaF;
    end
  end

  // Edges and bus conditions
  assign sclRise = sclF && !sclPrev_reg;
  assign sclFall = !sclF && sclPrev_reg;
  assign startCond = sclF && sclPrev_reg && sdaPrev_reg && !sdaF; // [RULE3]
  assign stopCond = sclF && sclPrev_reg && !sdaPrev_reg && sdaF; // [RULE3]

  // Byte including the bit arriving on this clock rise
  assign rxNow = {rxByte_reg[6:0], sdaF};

  ////////////////////////////////////////////////////////////////////////
  // Straps are caught once, on the first cycle configuration is valid;
  // later strap wiggles cannot move the identity mid-transfer.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      strapsTaken_reg <= 1'b0;
      modeOn_reg <= 1'b0;
      slaveId_reg <= DEFAULT_SLAVE_ID;
    end else if (configValid && !strapsTaken_reg) begin
      strapsTaken_reg <= 1'b1;
      modeOn_reg <= serialMgmtModeStrap; // [RULE8]
      slaveId_reg <= addrOverrideStrap ? addrStrap : DEFAULT_SLAVE_ID; // [RULE11] [RULE10]
    end
  end

  // Port is live only when configured, selected and at full power
  assign active = strapsTaken_reg && modeOn_reg && configValid && fullPowerState; // [RULE17] [RULE18]

  ////////////////////////////////////////////////////////////////////////
  // Bus busy between start and stop; a repeated start leaves it set
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busBusy <= 1'b0;
    end else if (!active) begin
      busBusy <= 1'b0;
    end else if (startCond) begin
      busBusy <= 1'b1; // [RULE4]
    end else if (stopCond) begin
      busBusy <= 1'b0;
    end
  end

  // The data pin is only ever pulled low; there is no clock driver
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mgmtSerialDataOut <= 1'b0;
    end else begin
      mgmtSerialDataOut <= 1'b0; // [RULE2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit shifter: receive states sample on the clock rise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxByte_reg <= 8'h00;
    end else if (active && sclRise) begin
      rxByte_reg <= rxNow; // [RULE5]
    end
  end

  // Master acknowledge is sampled on the ninth rise of each read byte
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mstAck_reg <= 1'b0;
    end else if (active && sclRise && state_reg == ST_MSTACK) begin
      mstAck_reg <= !sdaF; // [RULE6]
    end
  end

  // Read side effects fire once the third byte has been acked
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdCommit <= 1'b0;
    end else begin
      regRdCommit <= active && sclRise && state_reg == ST_MSTACK && !sdaF
                     && byteIdx_reg == COMMIT_BYTE; // [RULE24]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protocol engine. Data changes only just after a clock fall, which
  // the filter delay turns into well over 100 ns of hold time.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE; // [RULE26]
      afterAck_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      byteIdx_reg <= 2'h0;
      regAddr <= ADDR_RESET; // [RULE26]
      txWord_reg <= '0;
      wrWord_reg <= '0;
      mgmtSerialDataOeN <= 1'b1;
      regRdStrobe <= 1'b0;
    end else begin
      regRdStrobe <= 1'b0;
      if (!active) begin
        // Pins have no effect; stay released and idle
        state_reg <= ST_IDLE; // [RULE17] [RULE18]
        mgmtSerialDataOeN <= 1'b1;
      end else if (startCond) begin
        // Start or repeated start: any partial word is dropped
        state_reg <= ST_CTRL; // [RULE4] [RULE22] [RULE14]
        bitCnt_reg <= 4'h0;
        byteIdx_reg <= 2'h0;
        mgmtSerialDataOeN <= 1'b1;
      end else if (stopCond) begin
        state_reg <= ST_IDLE; // [RULE22] [RULE14]
        mgmtSerialDataOeN <= 1'b1;
      end else begin
        case (state_reg)
          ST_CTRL, ST_REGADR, ST_WRDATA: begin
            if (sclRise) begin
              bitCnt_reg <= bitCnt_reg + 4'h1; // [RULE5]
            end
            if (sclFall && bitCnt_reg == BITS_PER_BYTE) begin
              bitCnt_reg <= 4'h0;
              if (state_reg == ST_CTRL) begin
                if (rxByte_reg[7:1] == slaveId_reg) begin
                  mgmtSerialDataOeN <= 1'b0; // [RULE12] [RULE6]
                  state_reg <= ST_SLVACK;
                  afterAck_reg <= rxByte_reg[0] ? ST_RDLOAD : ST_REGADR; // [RULE13] [RULE15]
                end else begin
                  state_reg <= ST_IGNORE; // [RULE12]
                end
              end else if (state_reg == ST_REGADR) begin
                regAddr <= {rxByte_reg, 2'b00}; // [RULE16] [RULE14]
                byteIdx_reg <= 2'h0;
                mgmtSerialDataOeN <= 1'b0; // [RULE13]
                state_reg <= ST_SLVACK;
                afterAck_reg <= ST_WRDATA;
              end else begin
                wrWord_reg <= {wrWord_reg[DATA_W-9:0], rxByte_reg};
                byteIdx_reg <= byteIdx_reg + 2'h1;
                afterAck_reg <= ST_WRDATA;
                if (byteIdx_reg != LAST_BYTE) begin
                  mgmtSerialDataOeN <= 1'b0;
                  state_reg <= ST_SLVACK;
                end else if (fifoInReady) begin
                  // Full word: it is pushed now and the address steps
                  regAddr <= regAddr + ADDR_STEP; // [RULE22] [RULE21]
                  mgmtSerialDataOeN <= 1'b0;
                  state_reg <= ST_SLVACK;
                end else begin
                  // Buffer full: refuse the byte rather than lose it
                  state_reg <= ST_IGNORE;
                end
              end
            end
          end
          ST_SLVACK: begin
            // Hold the acknowledge through the ninth high period
            if (sclFall) begin
              mgmtSerialDataOeN <= 1'b1; // [RULE6]
              state_reg <= afterAck_reg;
            end
          end
          ST_RDLOAD: begin
            // Whole word is captured before its first bit goes out
            txWord_reg <= {regRdData[DATA_W-2:0], 1'b0}; // [RULE23]
            mgmtSerialDataOeN <= regRdData[DATA_W-1]; // [RULE15]
            regRdStrobe <= 1'b1;
            bitCnt_reg <= 4'h0;
            byteIdx_reg <= 2'h0;
            state_reg <= ST_RDDATA;
          end
          ST_RDDATA: begin
            if (sclRise) begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
            if (sclFall) begin
              if (bitCnt_reg == BITS_PER_BYTE) begin
                mgmtSerialDataOeN <= 1'b1; // [RULE6]
                state_reg <= ST_MSTACK;
              end else begin
                mgmtSerialDataOeN <= txWord_reg[DATA_W-1]; // [RULE5]
                txWord_reg <= {txWord_reg[DATA_W-2:0], 1'b0};
              end
            end
          end
          ST_MSTACK: begin
            if (sclFall) begin
              bitCnt_reg <= 4'h0;
              if (!mstAck_reg) begin
                // Nack: release and wait for stop or start
                state_reg <= ST_IGNORE; // [RULE7]
                if (byteIdx_reg == LAST_BYTE) begin
                  regAddr <= regAddr + ADDR_STEP; // [RULE21]
                end
              end else if (byteIdx_reg == LAST_BYTE) begin
                // Ack on the fourth byte: next register, wrapping to zero
                regAddr <= regAddr + ADDR_STEP; // [RULE21]
                state_reg <= ST_RDLOAD;
              end else begin
                byteIdx_reg <= byteIdx_reg + 2'h1;
                mgmtSerialDataOeN <= txWord_reg[DATA_W-1];
                txWord_reg <= {txWord_reg[DATA_W-2:0], 1'b0};
                state_reg <= ST_RDDATA;
              end
            end
          end
          ST_IGNORE: begin
            mgmtSerialDataOeN <= 1'b1; // [RULE12] [RULE7]
          end
          ST_IDLE: begin
            mgmtSerialDataOeN <= 1'b1;
          end
          default: begin
            state_reg <= ST_IDLE;
            mgmtSerialDataOeN <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completed writes enter the buffer on the fourth byte's last fall
  assign fifoInValid = active && !startCond && !stopCond && state_reg == ST_WRDATA
                       && sclFall && bitCnt_reg == BITS_PER_BYTE
                       && byteIdx_reg == LAST_BYTE; // [RULE22]
  assign fifoInData = {regAddr, wrWord_reg[DATA_W-9:0], rxByte_reg};

  mgmt_wr_fifo #(
    .WIDTH(WR_W),
    .DEPTH(WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // Output stage keeps the write port straight from flops
  assign fifoOutReady = !regWrValid || regWrReady;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regWrValid <= 1'b0;
      regWrAddr <= ADDR_RESET;
      regWrData <= '0;
    end else if (fifoOutReady) begin
      regWrValid <= fifoOutValid;
      if (fifoOutValid) begin
        regWrAddr <= fifoOutData[WR_W-1:DATA_W];
        regWrData <= fifoOutData[DATA_W-1:0];
      end
    end
  end
endmodule : i2c_slave_mgmt_port

/* i2c_slave_mgmt_port_properties.sv */
// Concurrent checks on the ports of the serial management slave port
`timescale 1ns/1ps
module i2c_slave_mgmt_port_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bus pins
  input wire logic mgmtSerialClockPin,
  input wire logic mgmtSerialDataIn,
  input wire logic mgmtSerialDataOut,
  input wire logic mgmtSerialDataOeN,
  // Gating
  input wire logic configValid,
  input wire logic fullPowerState,
  // Register ports
  input wire logic [i2c_mgmt_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic regRdStrobe,
  input wire logic regRdCommit,
  input wire logic regWrValid,
  input wire logic regWrReady,
  input wire logic [i2c_mgmt_pkg::REG_ADDR_W-1:0] regWrAddr,
  input wire logic [i2c_mgmt_pkg::DATA_W-1:0] regWrData,
  // Status
  input wire logic busBusy
);
  import i2c_mgmt_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////
  // Pin checks
  AST_DRIVE_LOW: assert property (mgmtSerialDataOut == 1'b0)
    else $error("data out not low");
  AST_PULL_SCL_LOW: assert property ($fell(mgmtSerialDataOeN) |-> !mgmtSerialClockPin)
    else $error("data pulled low while clock high");
  AST_START_FILT: assert property ($rose(busBusy) |-> $past(mgmtSerialDataIn, 1) == 1'b0
    && $past(mgmtSerialDataIn, 4) == 1'b0 && $past(mgmtSerialClockPin, 4))
    else $error("busy without start");
  AST_STOP_SEEN: assert property ($fell(busBusy) |-> ($past(mgmtSerialDataIn)
    && $past(mgmtSerialClockPin)) || !$past(configValid) || !$past(fullPowerState))
    else $error("busy fell without stop");
  AST_INERT: assert property ((!configValid || !fullPowerState) ##1 (!configValid || !fullPowerState)
    |-> mgmtSerialDataOeN && !regRdStrobe)
    else $error("port active while gated");
  // Register side checks
  AST_STRB_PULSE: assert property (regRdStrobe |-> $stable(regAddr) ##1 !regRdStrobe)
    else $error("strobe not one pulse");
  AST_COMMIT_PULSE: assert property (regRdCommit |-> busBusy ##1 !regRdCommit)
    else $error("commit outside frame");
  AST_WORD_ALIGN: assert property (regAddr[1:0] == 2'b00
    && (!regWrValid || regWrAddr[1:0] == 2'b00))
    else $error("address unaligned");
  AST_WR_HOLD: assert property (regWrValid && !regWrReady |=> regWrValid
    && $stable(regWrAddr) && $stable(regWrData))
    else $error("write changed while stalled");
  AST_WR_TAKEN: assert property ($fell(regWrValid) |-> $past(regWrReady))
    else $error("write dropped");
endmodule : i2c_slave_mgmt_port_checker

bind i2c_slave_mgmt_port i2c_slave_mgmt_port_checker i2c_slave_mgmt_port_checker_i (
  .mclk(mclk), .rstn(rstn), .mgmtSerialClockPin(mgmtSerialClockPin),
  .mgmtSerialDataIn(mgmtSerialDataIn), .mgmtSerialDataOut(mgmtSerialDataOut),
  .mgmtSerialDataOeN(mgmtSerialDataOeN), .configValid(configValid),
  .fullPowerState(fullPowerState), .regAddr(regAddr), .regRdStrobe(regRdStrobe),
  .regRdCommit(regRdCommit), .regWrValid(regWrValid), .regWrReady(regWrReady),
  .regWrAddr(regWrAddr), .regWrData(regWrData), .busBusy(busBusy));

/* i2c_host_model.sv */
// Behavioural bus master that drives the serial clock and data lines
`timescale 1ns/1ps
module i2c_host_model (
  // Clock
  input wire logic mclk,
  // Bus lines
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaOut
);
  //////////////////////////////////////////////////
  // Lines rest high; clock still between frames
  initial begin
    sclOut = 1'b1;
    sdaOut = 1'b1;
  end
  // Wait whole system clock cycles
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // Start: data falls while clock high
  task automatic bus_start();
    tick(8);
    sdaOut <= 1'b1;
    tick(44);
    sclOut <= 1'b1;
    tick(40);
    sdaOut <= 1'b0;
    tick(40);
    sclOut <= 1'b0;
  endtask : bus_start
  // Stop: data rises while clock high
  task automatic bus_stop();
    tick(8);
    sdaOut <= 1'b0;
    tick(44);
    sclOut <= 1'b1;
    tick(40);
    sdaOut <= 1'b1;
    tick(40);
  endtask : bus_stop
  // 100-cycle pulse (400 kHz); data set low, sampled mid high
  task automatic bus_bit(input logic b, output logic r);
    tick(8);
    sdaOut <= b;
    tick(44);
    sclOut <= 1'b1;
    tick(24);
    r = sdaLine;
    tick(24);
    sclOut <= 1'b0;
  endtask : bus_bit
  // Byte out MSB first, then release for the answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(b[i], r);
    end
    bus_bit(1'b1, r);
    ack = ~r;
  endtask : send_byte
  // Byte in; ack asks for more
  task automatic recv_byte(input logic ackOut, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, r);
      b[i] = r;
    end
    bus_bit(~ackOut, r);
  endtask : recv_byte
endmodule : i2c_host_model

/* i2c_slave_mgmt_port_bench.sv */
// Self-checking bench for the serial management slave port
`timescale 1ns/1ps
module i2c_slave_mgmt_port_bench;
  import i2c_mgmt_pkg::*;
  //////////////////////////////////////////////////
  // Signals
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic configValid = 1'b0;
  logic modeStrap;
  logic ovrStrap = 1'b0;
  logic [6:0] idStrap;
  logic fullPower = 1'b1;
  logic regWrReady = 1'b0;
  logic sclOut, sdaOut, sdaLine, ack;
  logic mgmtSerialDataOut, mgmtSerialDataOeN, regRdStrobe, regRdCommit, regWrValid, busBusy;
  logic [REG_ADDR_W-1:0] regAddr, regWrAddr;
  logic [DATA_W-1:0] regRdData, regWrData, word;
  logic [7:0] rb;
  logic [6:0] devId = DEFAULT_SLAVE_ID;
  logic [WR_W-1:0] wrSeen[$];
  int n_mismatch = 0;
  int check_count = 0;
  int commits = 0;
  // 40 MHz system clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // Register contents derived from the address
  function automatic logic [DATA_W-1:0] reg_word(input logic [REG_ADDR_W-1:0] a);
    return {8'hC3, 2'h0, ~a, 2'h0, a};
  endfunction : reg_word
  function automatic logic [DATA_W-1:0] wr_word(input int k);
    return 32'h5A0F_1E00 + DATA_W'(k);
  endfunction : wr_word
  assign regRdData = reg_word(regAddr);
  // Wired-AND with pull-up
  assign sdaLine = sdaOut & mgmtSerialDataOeN;
  // Count commits and taken words
  always @(posedge mclk) begin
    if (regRdCommit === 1'b1)
      commits++;
    if (regWrValid === 1'b1 && regWrReady === 1'b1)
      wrSeen.push_back({regWrAddr, regWrData});
  end
  i2c_slave_mgmt_port i2c_slave_mgmt_port_i (
    .mclk(mclk), .rstn(rstn), .mgmtSerialClockPin(sclOut), .mgmtSerialDataIn(sdaLine),
    .mgmtSerialDataOut(mgmtSerialDataOut), .mgmtSerialDataOeN(mgmtSerialDataOeN),
    .configValid(configValid), .serialMgmtModeStrap(modeStrap), .addrOverrideStrap(ovrStrap),
    .addrStrap(idStrap), .fullPowerState(fullPower), .regAddr(regAddr),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .regRdCommit(regRdCommit),
    .regWrValid(regWrValid), .regWrReady(regWrReady), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .busBusy(busBusy));
  i2c_host_model i2c_host_model_i (.mclk(mclk), .sdaLine(sdaLine), .sclOut(sclOut),
    .sdaOut(sdaOut));
  //////////////////////////////////////////////////
  // Compare tasks
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [WR_W-1:0] got, input logic [WR_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  // Access tasks
  task automatic ctrl(input logic [6:0] id, input logic dir, input logic expAck);
    i2c_host_model_i.bus_start();
    i2c_host_model_i.send_byte({id, dir}, ack);
    chk_bit(ack, expAck);
  endtask : ctrl
  task automatic set_addr(input logic [7:0] ab);
    ctrl(devId, 1'b0, 1'b1);
    i2c_host_model_i.send_byte(ab, ack);
    chk_bit(ack, 1'b1);
  endtask : set_addr
  // Sink stalled: buffer plus output stage hold five words, the sixth is nacked
  task automatic write_words(input logic [7:0] ab, input int n);
    set_addr(ab);
    for (int w = 0; w < n; w++) begin
      word = wr_word(w);
      for (int b = 3; b >= 0; b--) begin
        i2c_host_model_i.send_byte(word[8*b +: 8], ack);
        chk_bit(ack, !(w == WR_FIFO_DEPTH + 1 && b == 0));
      end
    end
    i2c_host_model_i.bus_stop();
  endtask : write_words
  // Address, repeated start, n words, nack on the last
  task automatic read_words(input logic [7:0] ab, input int n);
    logic [REG_ADDR_W-1:0] a;
    a = {ab, 2'b00};
    set_addr(ab);
    ctrl(devId, 1'b1, 1'b1);
    chk_bit(busBusy, 1'b1);
    for (int w = 0; w < n; w++) begin
      for (int b = 3; b >= 0; b--) begin
        i2c_host_model_i.recv_byte(!(w == n - 1 && b == 0), rb);
        word[8*b +: 8] = rb;
      end
      chk_word(WR_W'(word), WR_W'(reg_word(a)));
      a = a + ADDR_STEP;
    end
    i2c_host_model_i.bus_stop();
    chk_word(WR_W'(regAddr), WR_W'(a));
  endtask : read_words
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // Watchdog well past the test length
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end
  //////////////////////////////////////////////////
  // Main sequence
  initial begin
    modeStrap <= 1'b1;
    idStrap <= 7'h55;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    i2c_host_model_i.tick(2);
    chk_word(WR_W'(regAddr), WR_W'(ADDR_RESET));
    chk_bit(mgmtSerialDataOeN, 1'b1);
    ctrl(devId, 1'b0, 1'b0);
    i2c_host_model_i.bus_stop();
    configValid <= 1'b1;
    fullPower <= 1'b0;
    i2c_host_model_i.tick(20);
    ctrl(devId, 1'b0, 1'b0);
    i2c_host_model_i.bus_stop();
    fullPower <= 1'b1;
    i2c_host_model_i.tick(20);
    ctrl(7'h0B, 1'b0, 1'b0);
    i2c_host_model_i.send_byte(8'h00, ack);
    chk_bit(ack, 1'b0);
    i2c_host_model_i.bus_stop();
    // Partial word then stop
    set_addr(8'h10);
    i2c_host_model_i.send_byte(8'hEE, ack);
    chk_bit(ack, 1'b1);
    i2c_host_model_i.bus_stop();
    chk_word(WR_W'(regAddr), WR_W'(10'h040));
    write_words(8'h05, WR_FIFO_DEPTH + 2);
    chk_bit(regWrValid, 1'b1);
    regWrReady <= 1'b1;
    i2c_host_model_i.tick(20);
    chk_word(WR_W'(wrSeen.size()), WR_W'(WR_FIFO_DEPTH + 1));
    for (int w = 0; w < WR_FIFO_DEPTH + 1; w++) begin
      chk_word(wrSeen[w], {REG_ADDR_W'(20 + 4 * w), wr_word(w)});
    end
    read_words(8'h3F, 2);
    read_words(8'hFF, 2);
    chk_word(WR_W'(commits), WR_W'(4));
    // Second reset, strapped identity
    rstn <= 1'b0;
    configValid <= 1'b0;
    ovrStrap <= 1'b1;
    i2c_host_model_i.tick(8);
    rstn <= 1'b1;
    i2c_host_model_i.tick(2);
    configValid <= 1'b1;
    i2c_host_model_i.tick(20);
    ctrl(DEFAULT_SLAVE_ID, 1'b0, 1'b0);
    i2c_host_model_i.bus_stop();
    devId = 7'h55;
    set_addr(8'h01);
    i2c_host_model_i.bus_stop();
    final_report();
  end
endmodule : i2c_slave_mgmt_port_bench
